/* File: sbi_snoop_intervention.v */
`timescale 1ns/100ps
`default_nettype none
`include "sbi_defines.vh"

module sbi_snoop_intervention #(
  parameter INDEX_W = 6
) (
  input wire clock,
  input wire rst_n,
  input wire groupAddrLatchEn,
  input wire [63:0] adIn,
  input wire blockSizeInN,
  input wire groupSlaveAck,
  input wire groupTransferHold,
  input wire grantN,
  input wire exclusiveAllowed,
  input wire groupBlockCacheable,
  input wire groupSharedHit,
  input wire ownOp,
  input wire coreFillEn,
  input wire [INDEX_W-1:0] coreFillIndex,
  input wire [26-INDEX_W-1:0] coreFillTag,
  input wire [1:0] coreFillState,
  input wire [63:0] wbData,
  input wire wbDataValid,
  output reg dirtyLineN,
  output reg sharedHitN,
  output reg arbRequestN,
  output reg addrLatchEnN,
  output reg blockSizeN,
  output reg transferHoldN,
  output reg [63:0] adOut,
  output reg adOe,
  output reg fillDone,
  output reg [1:0] fillState,
  output reg wbReq,
  output reg [INDEX_W-1:0] wbIndex,
  output reg [1:0] wbQword
);

  localparam TAG_W = 26 - INDEX_W;
  localparam DW = TAG_W + 2;
  localparam TAG_LO = `SBI_LINE_LO + INDEX_W;

  localparam S_INIT = 3'h0;
  localparam S_IDLE = 3'h1;
  localparam S_LOOK = 3'h2;
  localparam S_ACK = 3'h3;
  localparam S_GNT = 3'h4;
  localparam S_ADDR = 3'h5;
  localparam S_DATA = 3'h6;

  // bus is synchronous to clock: one input register stage
  reg galeR;
  reg [63:0] adR;
  reg blkR;
  reg ackR;
  reg holdR;
  reg gntR;
  reg exclR;
  reg cacheR;
  reg shareR;

  reg [2:0] state;
  reg [INDEX_W-1:0] initCount;
  reg [INDEX_W-1:0] opIndex;
  reg [TAG_W-1:0] opTag;
  // address bit 31 is not in the tag: lines alias across the two halves
  reg opTop;
  reg [1:0] opQword;
  reg [7:0] opBe;
  reg [2:0] opType;
  reg opBlock;
  reg sawAck;
  reg [2:0] sent;
  reg ownExcl;
  reg ownCache;

  wire [DW-1:0] rdData;
  reg memWr;
  reg [INDEX_W-1:0] memWrAddr;
  reg [DW-1:0] memWrData;

  wire [TAG_W-1:0] lineTag = rdData[DW-1:2];
  wire [1:0] lineState = rdData[1:0];
  wire hit = (lineTag == opTag) && (lineState != `SBI_ST_INV);
  wire isWrite = (opType == `SBI_TYPE_MEM_WR);
  wire dataBeat = ackR && !holdR;

  function [1:0] fill_state;
    input [1:0] req;
    input excl;
    input cache;
    input shared;
    begin
      if (!cache) begin
        fill_state = `SBI_ST_INV;
      end else if ((req == `SBI_ST_EXC || req == `SBI_ST_MOD) && (!excl || shared)) begin
        fill_state = `SBI_ST_SHR;
      end else begin
        fill_state = req;
      end
    end
  endfunction

  sbi_tag_ram #(
    .AW(INDEX_W),
    .DW(DW)
  ) tagRam (
    .clock(clock),
    .wrEn(memWr),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddr(adR[TAG_LO-1:`SBI_LINE_LO]),
    .rdData(rdData)
  );

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      galeR <= 1'b0;
      adR <= 64'h0;
      blkR <= 1'b0;
      ackR <= 1'b0;
      holdR <= 1'b0;
      gntR <= 1'b0;
      exclR <= 1'b0;
      cacheR <= 1'b0;
      shareR <= 1'b0;
    end else begin
      galeR <= groupAddrLatchEn;
      adR <= adIn;
      blkR <= !blockSizeInN;
      ackR <= groupSlaveAck;
      holdR <= groupTransferHold;
      gntR <= !grantN;
      exclR <= exclusiveAllowed;
      cacheR <= groupBlockCacheable;
      shareR <= groupSharedHit;
    end
  end

  // tag write port: reset sweep, snoop invalidate, else core fill
  always @* begin
    memWr = 1'b0;
    memWrAddr = coreFillIndex;
    memWrData = {coreFillTag, fill_state(coreFillState, ownExcl, ownCache, shareR)};
    if (state == S_INIT) begin
      memWr = 1'b1;
      memWrAddr = initCount;
      memWrData = {DW{1'b0}};
    end else if (state == S_LOOK && hit && isWrite && opBlock) begin
      memWr = 1'b1;
      memWrAddr = opIndex;
      memWrData = {opTag, `SBI_ST_INV};
    end else if (state == S_DATA && sent == `SBI_QWORDS) begin
      memWr = 1'b1;
      memWrAddr = opIndex;
      memWrData = {opTag, `SBI_ST_INV};
    end else if (coreFillEn) begin
      memWr = 1'b1;
    end
  end

  // cacheability of own operations, caught at the data beat
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ownExcl <= 1'b0;
      ownCache <= 1'b0;
      fillDone <= 1'b0;
      fillState <= `SBI_ST_INV;
    end else begin
      if (ownOp && dataBeat) begin
        ownExcl <= exclR;
        ownCache <= cacheR;
      end
      fillDone <= coreFillEn && !(memWr && memWrAddr != coreFillIndex) && state != S_INIT
        && !(state == S_LOOK && hit && isWrite && opBlock)
        && !(state == S_DATA && sent == `SBI_QWORDS);
      fillState <= fill_state(coreFillState, ownExcl, ownCache, shareR);
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_INIT;
      initCount <= {INDEX_W{1'b0}};
      opIndex <= {INDEX_W{1'b0}};
      opTag <= {TAG_W{1'b0}};
      opTop <= 1'b0;
      opQword <= 2'h0;
      opBe <= `SBI_BE_NONE;
      opType <= 3'h0;
      opBlock <= 1'b0;
      sawAck <= 1'b0;
      sent <= 3'h0;
      dirtyLineN <= 1'b1;
      sharedHitN <= 1'b1;
      arbRequestN <= 1'b1;
      addrLatchEnN <= 1'b1;
      blockSizeN <= 1'b1;
      transferHoldN <= 1'b1;
      adOut <= 64'h0;
      adOe <= 1'b0;
      wbReq <= 1'b0;
      wbIndex <= {INDEX_W{1'b0}};
      wbQword <= 2'h0;
    end else begin
      case (state)
        S_INIT: begin
          initCount <= initCount + {{(INDEX_W-1){1'b0}}, 1'b1};
          if (&initCount) begin
            state <= S_IDLE;
          end
        end
        S_IDLE: begin
          sawAck <= 1'b0;
          if (galeR && !ownOp) begin
            opIndex <= adR[TAG_LO-1:`SBI_LINE_LO];
            opTag <= adR[`SBI_ADDR_HI-1:TAG_LO];
            opTop <= adR[`SBI_ADDR_HI];
            opQword <= adR[`SBI_QW_HI:`SBI_QW_LO];
            opBe <= adR[`SBI_BE_HI:`SBI_BE_LO];
            opType <= adR[`SBI_TYPE_HI:`SBI_TYPE_LO];
            opBlock <= blkR;
            state <= S_LOOK;
          end
        end
        S_LOOK: begin
          state <= S_IDLE;
          if (hit && (opType == `SBI_TYPE_MEM_RD || opType == `SBI_TYPE_MEM_WR)) begin
            if (lineState == `SBI_ST_MOD && !(isWrite && opBlock)) begin
              dirtyLineN <= 1'b0;
              opBe <= isWrite ? ~opBe : `SBI_BE_ALL;
              state <= S_ACK;
            end else if (!isWrite && opBlock) begin
              sharedHitN <= 1'b0;
              state <= S_ACK;
            end
          end
        end
        S_ACK: begin
          if (ackR) begin
            sawAck <= 1'b1;
          end
          if (sawAck && !ackR) begin
            sharedHitN <= 1'b1;
            if (!dirtyLineN) begin
              arbRequestN <= 1'b0;
              state <= S_GNT;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_GNT: begin
          if (gntR) begin
            addrLatchEnN <= 1'b0;
            blockSizeN <= 1'b0;
            adOe <= 1'b1;
            adOut <= {15'h0, `SBI_TYPE_MEM_WR, 6'h0, opBe, opTop, opTag, opIndex, opQword, 3'h0};
            wbReq <= 1'b1;
            wbIndex <= opIndex;
            wbQword <= opQword;
            sent <= 3'h0;
            state <= S_ADDR;
          end
        end
        S_ADDR: begin
          addrLatchEnN <= 1'b1;
          dirtyLineN <= 1'b1;
          arbRequestN <= 1'b1;
          adOut <= wbData;
          transferHoldN <= wbDataValid;
          state <= S_DATA;
        end
        S_DATA: begin
          if (sent == `SBI_QWORDS) begin
            adOe <= 1'b0;
            blockSizeN <= 1'b1;
            transferHoldN <= 1'b1;
            wbReq <= 1'b0;
            state <= S_IDLE;
          end else if (dataBeat && transferHoldN) begin
            sent <= sent + 3'h1;
            wbQword <= wbQword + 2'h1;
            transferHoldN <= 1'b0;
          end else begin
            adOut <= wbData;
            transferHoldN <= wbDataValid;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // sbi_snoop_intervention

`default_nettype wire

/* File: sbi_defines.vh */
// Notes on behaviour
// - ownable negated forbids exclusive state, shared allowed
// - snoop hit on modified block asserts dirty-line
// - dirty-line asserted by third clock after latch
// - block write hitting modified: invalidate, no dirty-line
// - once granted, block write from original qword address
// - negate dirty-line after latch enable, before data
// - all parties synchronise on group hold during write-back
// - write-back drives complement of intercepted byte enables
// - other block writes enable all eight bytes
// - byte enables govern only the first qword
// - block read hit modified: dirty-line, grant, whole block
// - full block write hitting owned block: just invalidate
`ifndef SBI_DEFINES_VH
`define SBI_DEFINES_VH

`define SBI_AD_W 64
`define SBI_TYPE_HI 48
`define SBI_TYPE_LO 46
`define SBI_BE_HI 39
`define SBI_BE_LO 32
`define SBI_ADDR_HI 31
`define SBI_QW_HI 4
`define SBI_QW_LO 3
`define SBI_LINE_LO 5

`define SBI_TYPE_MEM_RD 3'h6
`define SBI_TYPE_MEM_WR 3'h7
`define SBI_BE_ALL 8'h00
`define SBI_BE_NONE 8'hFF

`define SBI_ST_INV 2'h0
`define SBI_ST_SHR 2'h1
`define SBI_ST_EXC 2'h2
`define SBI_ST_MOD 2'h3

`define SBI_QWORDS 3'h4

`endif

/* File: sbi_tag_ram.v */
`timescale 1ns/100ps
`default_nettype none

module sbi_tag_ram #(
  parameter AW = 6,
  parameter DW = 24
) (
  input wire clock,
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [DW-1:0] wrData,
  input wire [AW-1:0] rdAddr,
  output reg [DW-1:0] rdData
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule // sbi_tag_ram

`default_nettype wire

/* File: sbi_bus_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module sbi_bus_partner (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic groupAddrLatchEn,
  input wire logic dirtyLineN,
  input wire logic arbRequestN,
  input wire logic adOe,
  output logic groupSlaveAck,
  output logic grantN
);
  logic [2:0] ph;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 3'h0;
      groupSlaveAck <= 1'h0;
      grantN <= 1'h1;
    end else begin
      ph <= groupAddrLatchEn ? 3'h1 : ph + {2'h0, ph != 3'h0};
      groupSlaveAck <= adOe | (ph >= 3'h2 && ph <= 3'h4 && dirtyLineN);
      grantN <= arbRequestN | groupSlaveAck;
    end
  end
endmodule // sbi_bus_partner
`default_nettype wire

/* File: sbi_snoop_props.sv */
`timescale 1ns/100ps
`default_nettype none
module sbi_snoop_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic groupAddrLatchEn,
  input wire logic [63:0] adIn,
  input wire logic blockSizeInN,
  input wire logic grantN,
  input wire logic ownOp,
  input wire logic dirtyLineN,
  input wire logic arbRequestN,
  input wire logic addrLatchEnN,
  input wire logic [63:0] adOut,
  input wire logic adOe,
  input wire logic wbReq,
  input wire logic [1:0] wbQword
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_late;
    $fell(dirtyLineN) |-> $past(groupAddrLatchEn, 3) || $past(groupAddrLatchEn, 4);
  endproperty
  a_late: assert property (p_late) else $error("dirty late");
  property p_drop; $rose(dirtyLineN) |-> !$past(addrLatchEnN); endproperty
  a_drop: assert property (p_drop) else $error("dirty drop");
  property p_hold; !addrLatchEnN |-> !dirtyLineN && adOe; endproperty
  a_hold: assert property (p_hold) else $error("dirty gone");
  property p_type; !addrLatchEnN |-> adOut[48:46] == 3'h7; endproperty
  a_type: assert property (p_type) else $error("wb type");
  property p_go; $fell(grantN) && !arbRequestN |-> ##[1:3] !addrLatchEnN; endproperty
  a_go: assert property (p_go) else $error("no wb");
  property p_bw;
    groupAddrLatchEn && !ownOp && !blockSizeInN && adIn[48:46] == 3'h7 && dirtyLineN
      && arbRequestN |-> ##1 dirtyLineN [*4];
  endproperty
  a_bw: assert property (p_bw) else $error("dirty on bw");
  property p_req; $fell(arbRequestN) |-> !dirtyLineN; endproperty
  a_req: assert property (p_req) else $error("bad req");
  property p_wrap;
    wbReq && $past(wbReq) && wbQword != $past(wbQword) |-> wbQword == $past(wbQword) + 2'h1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("qword order");
  c_dirty: cover property ($fell(dirtyLineN));
  c_wb: cover property (!addrLatchEnN);
  c_req: cover property ($fell(arbRequestN));
endmodule // sbi_snoop_props
bind sbi_snoop_intervention sbi_snoop_props u_props (.*);
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam A = 32'h0001_2368;
  localparam B = 32'h0004_5640;
  logic clock = 1'h0, rst_n = 1'h0, groupAddrLatchEn = 1'h0, blockSizeInN = 1'h1;
  logic exclusiveAllowed = 1'h1, ownOp = 1'h0, coreFillEn = 1'h0, wbDataValid = 1'h1;
  logic groupBlockCacheable = 1'h1, groupSharedHit = 1'h0;
  logic [63:0] adIn = 64'h0, wbData = 64'h5A;
  logic [2:0] coreFillIndex = 3'h0;
  logic [22:0] coreFillTag = 23'h0;
  logic [1:0] coreFillState = 2'h0;
  logic groupSlaveAck, grantN, dirtyLineN, sharedHitN, arbRequestN, addrLatchEnN;
  logic blockSizeN, transferHoldN, adOe, fillDone, wbReq, groupTransferHold;
  logic [63:0] adOut;
  logic [1:0] fillState, wbQword;
  logic [2:0] wbIndex;
  logic [1:0] q;
  logic slowHold = 1'h0;
  int fails = 0, checked = 0, k, n;
  assign groupTransferHold = !transferHoldN || slowHold;
  always #25 clock = ~clock;
  sbi_snoop_intervention #(.INDEX_W(3)) dut (.*);
  sbi_bus_partner u_bus (.*);
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'h1) begin
      fails++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task fill(input logic [31:0] a, input logic [1:0] s);
    // own block read first: its data beat sets the cacheability of the fill
    groupSharedHit = !exclusiveAllowed;
    ownOp = 1'h1;
    snoop(3'h6, 8'h00, 1'h1, a);
    cyc(6);
    ownOp = 1'h0;
    groupSharedHit = 1'h0;
    {coreFillTag, coreFillIndex} = a[30:5];
    coreFillState = s;
    coreFillEn = 1'h1;
    cyc(1);
    coreFillEn = 1'h0;
  endtask
  task snoop(input logic [2:0] t, input logic [7:0] be, input logic blk, input logic [31:0] a);
    adIn = {15'h0, t, 6'h0, be, a};
    blockSizeInN = !blk;
    groupAddrLatchEn = 1'h1;
    cyc(1);
    groupAddrLatchEn = 1'h0;
  endtask
  task quiet(input int n);
    repeat (n) begin
      cyc(1);
      chk(dirtyLineN === 1'h1 && sharedHitN === 1'h1, "hit seen");
    end
  endtask
  task wback(input logic [7:0] be, input logic [31:0] a, input int h);
    cyc(2);
    chk(groupSlaveAck === 1'h1 && dirtyLineN === 1'h0, "dirty with data");
    k = 0;
    while (addrLatchEnN !== 1'h0 && k < 20) begin
      cyc(1);
      k++;
    end
    chk(adOut[48:46] === 3'h7 && adOut[39:32] === be && blockSizeN === 1'h0, "wb status");
    chk(adOut[31:3] === a[31:3] && wbQword === a[4:3] && wbIndex === a[7:5], "wb addr");
    q = wbQword;
    n = 0;
    if (h > 0) begin
      slowHold = 1'h1;
      cyc(h);
      slowHold = 1'h0;
      k = k + h;
    end
    while (adOe === 1'h1 && k < 50) begin
      cyc(1);
      k++;
      if (wbQword !== q) begin
        n++;
      end
      q = wbQword;
    end
    chk(k < 50 && dirtyLineN === 1'h1 && n == 4, "wb end");
    cyc(2);
  endtask
  task t_read;
    fill(A, 2'h3);
    snoop(3'h6, 8'h0F, 1'h0, A);
    wback(8'h00, A, 0);
    fill(A, 2'h3);
    snoop(3'h6, 8'h00, 1'h1, A);
    wback(8'h00, A, 0);
    snoop(3'h6, 8'h00, 1'h0, A);
    quiet(8);
    $display("read hit done");
  endtask
  task t_part;
    fill(A, 2'h3);
    snoop(3'h7, 8'h07, 1'h0, A);
    wback(8'hF8, A, 3);
    $display("partial write done");
  endtask
  task t_blkwr;
    fill(A, 2'h3);
    fill(B, 2'h2);
    snoop(3'h6, 8'h00, 1'h1, B);
    cyc(2);
    chk(sharedHitN === 1'h0 && dirtyLineN === 1'h1, "no shared_hit_n");
    cyc(6);
    chk(sharedHitN === 1'h1, "shared_hit_n stuck");
    snoop(3'h7, 8'h00, 1'h1, A);
    quiet(6);
    snoop(3'h7, 8'h00, 1'h1, B);
    quiet(6);
    snoop(3'h6, 8'h00, 1'h1, A);
    quiet(6);
    snoop(3'h6, 8'h00, 1'h1, B);
    quiet(6);
    $display("block write done");
  endtask
  task t_own;
    for (int i = 0; i < 2; i++) begin
      exclusiveAllowed = i[0];
      fill(B, 2'h2);
      chk(fillDone === 1'h1 && fillState === (i[0] ? 2'h2 : 2'h1), "fill state");
    end
    $display("ownable done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    cyc(12);
    rst_n = 1'h1;
    cyc(12);
    t_read;
    t_part;
    t_blkwr;
    t_own;
    end_of_test;
  end
  initial begin
    #200000;
    fails++;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
